// [include/cmp_pkg.sv]
/*
  Shared constants and carrier types for the comparator control bank.
  Assumes an 8-bit APB byte address and an 8-bit register width.
*/
package cmp_pkg;

  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_SYNC_CTL_A = 8'h00;
  localparam logic [7:0] OFF_SYNC_CTL_B = 8'h04;
  localparam logic [7:0] OFF_SYNC_DEBOUNCE = 8'h08;
  localparam logic [7:0] OFF_SYNC_DELAY = 8'h0C;
  localparam logic [7:0] OFF_PROT_CTL_A_BASE = 8'h20; // + 4*n, n = 1..5
  localparam logic [7:0] OFF_PROT_CTL_B_BASE = 8'h40; // + 4*n, n = 1..5
  localparam logic [7:0] OFF_PROT_DAC_BASE = 8'h60; // + 4*n, n = 1..5
  localparam logic [7:0] OFF_LEB_CTL = 8'h80;
  localparam logic [7:0] OFF_ACT_CTL_A = 8'h84;
  localparam logic [7:0] OFF_ACT_CTL_B = 8'h88;
  localparam logic [7:0] OFF_INT_STATUS = 8'h8C;
  localparam logic [7:0] OFF_INT_MASK = 8'h90;

  // ----------------------------------------
  // reset values and writable bits
  // ----------------------------------------
  localparam logic [7:0] RST_SYNC_CTL_A = 8'h20;
  localparam logic [7:0] RST_SYNC_CTL_B = 8'h04;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] WM_SYNC_CTL_A = 8'h7F;
  localparam logic [7:0] WM_SYNC_DEBOUNCE = 8'hBF;
  localparam logic [7:0] WM_SYNC_DELAY = 8'h3F;
  localparam logic [7:0] WM_PROT_CTL_A = 8'h7F;
  localparam logic [7:0] WM_PROT_CTL_B = 8'hEF;
  localparam logic [7:0] WM_ACT_CTL_A = 8'hFD;
  localparam logic [7:0] WM_ACT_CTL_B = 8'h03;
  localparam logic [7:0] WM_ALL = 8'hFF;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int BIT_RAW_OUT = 7;
  localparam int BIT_CALIB_MODE = 6;
  localparam int BIT_POWER_EN = 7;
  localparam int BIT_OUT_INVERT = 3;
  localparam int BIT_TRIG_SRC = 2;
  localparam int BIT_FDBDL = 7;
  localparam int BIT_CHAN_VOD = 4;
  localparam int BIT_BLANK_EN = 7;
  localparam int NUM_CHAN = 6;

  // channel 4 interrupts on rising edge, all others on falling
  localparam logic [5:0] IRQ_RISE_SEL = 6'h10;

  // ----------------------------------------
  // debounce timing counts (ticks of the debounce clock)
  // ----------------------------------------
  localparam logic [5:0] DB_SAT_CODE = 6'h30;
  localparam logic [5:0] DB_SAT_TICKS = 6'h30;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [3:0] {
    RID_SYNC_A, RID_SYNC_B, RID_SYNC_DB, RID_SYNC_DLY, RID_PROT_A, RID_PROT_B,
    RID_DAC, RID_LEB, RID_ACT_A, RID_ACT_B, RID_STAT, RID_MASK, RID_NONE
  } reg_id_t;

  typedef struct packed {
    reg_id_t id;
    logic [2:0] ch;
  } reg_dec_t;

  // filtered signals and the blanking enable to the pulse generator, timers and converter
  typedef struct packed {
    logic sync_delayed_trigger;
    logic sync_filtered_out;
    logic [5:1] chan_filtered_out;
    logic chan3_blanking_enable;
  } route_t;

  // settings towards the analog comparator cores
  typedef struct packed {
    logic [5:0] chan_power_enable;
    logic [5:0] calib_mode;
    logic [5:0] sync_offset_trim;
    logic [7:0] sync_ctl_b;
    logic [5:1][7:0] prot_ctl_a;
    logic [5:1][7:0] prot_dac;
    logic [7:0] blanking;
    logic [7:0] action_a;
    logic [7:0] action_b;
  } analog_ctl_t;

endpackage

// [hw/cmp_debounce.sv]
/*
  Debounce / delay filter for one comparator signal.
  Assumes din is already synchronous to pclk and tick is a one-cycle enable.
*/
`timescale 1ns/1ps

module cmp_debounce (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic tick,
  input wire logic [5:0] sel,
  // data
  input wire logic din,
  output logic dout
);
  import cmp_pkg::*;

  logic dout_r, dout_nxt;
  logic [5:0] cnt_r, cnt_nxt;
  logic [5:0] limit;

  // ----------------------------------------
  // filter
  // ----------------------------------------
  // codes 11xxxx saturate at the longest window
  assign limit = (sel >= DB_SAT_CODE) ? DB_SAT_TICKS : sel;

  // output follows only after input held for limit ticks
  always_comb begin
    dout_nxt = dout_r;
    cnt_nxt = cnt_r;
    if (sel == 6'h00) begin
      dout_nxt = din;
      cnt_nxt = 6'h00;
    end else if (din == dout_r) begin
      cnt_nxt = 6'h00;
    end else if (tick) begin
      if (cnt_r + 6'h01 >= limit) begin
        dout_nxt = din;
        cnt_nxt = 6'h00;
      end else begin
        cnt_nxt = cnt_r + 6'h01;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dout_r <= 1'b0;
      cnt_r <= 6'h00;
    end else begin
      dout_r <= dout_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign dout = dout_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_bypass;
    @(posedge pclk) disable iff (!presetn)
    sel == 6'h00 |=> dout == $past(din);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass code did not pass input");

  property p_glitch_held;
    @(posedge pclk) disable iff (!presetn)
    (sel > 6'h01 && $stable(sel) && din != dout && cnt_r == 6'h00) |=> dout == $past(dout);
  endproperty
  a_glitch_held: assert property (p_glitch_held) else $error("filter passed a short pulse");

endmodule

// [hw/cmp_bank.sv]
/*
  Comparator control bank: APB registers, output conditioning, edge
  interrupts and routing of filtered comparator outputs.
  Assumes comparator raw outputs may change at any time and are resynchronised
  here; the pulse input pin is used without a synchroniser; one clock, pclk at 20 MHz.
*/
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/1ps

// Contract
// - six channels, five protect, one sync
// - falling edge irq, channel 4 rising
// - route sync trigger, sync output, channel 4
// - channels 1..5 and blanking to pulse generator
// - sync raw output readable at bit 7
// - bit 6 selects calibration mode
// - six-bit trim, reset value 100000
// - sync enable bit powers the channel
// - debounce code selects filter length
// - select bit picks trigger source
// - invert bit flips sync output
module cmp_bank (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [cmp_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // analog side
  input wire logic [5:0] cmp_raw,
  input wire logic pulse_gen_input_pin,
  output cmp_pkg::analog_ctl_t analog_ctl,
  // internal consumers
  output cmp_pkg::route_t route,
  output logic [5:0] irq_pulse,
  output logic irq
);
  import cmp_pkg::*;

  // ----------------------------------------
  // register decode
  // ----------------------------------------
  function automatic reg_dec_t decode(input logic [ADDR_W-1:0] a);
    reg_dec_t d;
    d.ch = a[4:2];
    d.id = RID_NONE;
    if (a[1:0] != 2'b00) begin
      d.id = RID_NONE;
    end else if (a == OFF_SYNC_CTL_A) begin
      d.id = RID_SYNC_A;
    end else if (a == OFF_SYNC_CTL_B) begin
      d.id = RID_SYNC_B;
    end else if (a == OFF_SYNC_DEBOUNCE) begin
      d.id = RID_SYNC_DB;
    end else if (a == OFF_SYNC_DELAY) begin
      d.id = RID_SYNC_DLY;
    end else if (a == OFF_LEB_CTL) begin
      d.id = RID_LEB;
    end else if (a == OFF_ACT_CTL_A) begin
      d.id = RID_ACT_A;
    end else if (a == OFF_ACT_CTL_B) begin
      d.id = RID_ACT_B;
    end else if (a == OFF_INT_STATUS) begin
      d.id = RID_STAT;
    end else if (a == OFF_INT_MASK) begin
      d.id = RID_MASK;
    end else if (d.ch >= 3'd1 && d.ch <= 3'd5) begin
      if (a[7:5] == OFF_PROT_CTL_A_BASE[7:5]) d.id = RID_PROT_A;
      else if (a[7:5] == OFF_PROT_CTL_B_BASE[7:5]) d.id = RID_PROT_B;
      else if (a[7:5] == OFF_PROT_DAC_BASE[7:5]) d.id = RID_DAC;
    end
    return d;
  endfunction

  reg_dec_t dec;
  logic wr_en;
  assign dec = decode(paddr);
  assign wr_en = psel && penable && pwrite && (dec.id != RID_NONE);
  // zero wait states: every access completes in its access phase
  assign pready = 1'b1;
  assign pslverr = psel && penable && (dec.id == RID_NONE);

  // ----------------------------------------
  // register file
  // ----------------------------------------
  logic [7:0] sync_a_r, sync_a_nxt, sync_b_r, sync_b_nxt;
  logic [7:0] sync_db_r, sync_db_nxt, sync_dly_r, sync_dly_nxt;
  logic [5:1][7:0] prot_a_r, prot_a_nxt, prot_b_r, prot_b_nxt, dac_r, dac_nxt;
  logic [7:0] leb_r, leb_nxt, act_a_r, act_a_nxt, act_b_r, act_b_nxt;
  logic [5:0] stat_r, stat_nxt, mask_r, mask_nxt;
  logic [5:0] pulse_r, pulse_nxt;

  // masked write; read-only bits keep their stored zero
  always_comb begin
    sync_a_nxt = sync_a_r;
    sync_b_nxt = sync_b_r;
    sync_db_nxt = sync_db_r;
    sync_dly_nxt = sync_dly_r;
    prot_a_nxt = prot_a_r;
    prot_b_nxt = prot_b_r;
    dac_nxt = dac_r;
    leb_nxt = leb_r;
    act_a_nxt = act_a_r;
    act_b_nxt = act_b_r;
    mask_nxt = mask_r;
    // set wins over a same-cycle write-one clear
    stat_nxt = stat_r | pulse_r;
    if (wr_en) begin
      unique case (dec.id)
        RID_SYNC_A: sync_a_nxt = pwdata[7:0] & WM_SYNC_CTL_A;
        RID_SYNC_B: sync_b_nxt = pwdata[7:0];
        RID_SYNC_DB: sync_db_nxt = pwdata[7:0] & WM_SYNC_DEBOUNCE;
        RID_SYNC_DLY: sync_dly_nxt = pwdata[7:0] & WM_SYNC_DELAY;
        RID_PROT_A: prot_a_nxt[dec.ch] = pwdata[7:0] & WM_PROT_CTL_A;
        RID_PROT_B: prot_b_nxt[dec.ch] = pwdata[7:0] & WM_PROT_CTL_B;
        RID_DAC: dac_nxt[dec.ch] = pwdata[7:0];
        RID_LEB: leb_nxt = pwdata[7:0];
        RID_ACT_A: act_a_nxt = pwdata[7:0] & WM_ACT_CTL_A;
        RID_ACT_B: act_b_nxt = pwdata[7:0] & WM_ACT_CTL_B;
        RID_STAT: stat_nxt = (stat_r & ~pwdata[5:0]) | pulse_r;
        RID_MASK: mask_nxt = pwdata[5:0];
        RID_NONE: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a_r <= RST_SYNC_CTL_A;
      sync_b_r <= RST_SYNC_CTL_B;
      sync_db_r <= RST_ZERO;
      sync_dly_r <= RST_ZERO;
      prot_a_r <= '0;
      prot_b_r <= '0;
      dac_r <= '0;
      leb_r <= RST_ZERO;
      act_a_r <= RST_ZERO;
      act_b_r <= RST_ZERO;
      stat_r <= 6'h00;
      mask_r <= 6'h00;
    end else begin
      sync_a_r <= sync_a_nxt;
      sync_b_r <= sync_b_nxt;
      sync_db_r <= sync_db_nxt;
      sync_dly_r <= sync_dly_nxt;
      prot_a_r <= prot_a_nxt;
      prot_b_r <= prot_b_nxt;
      dac_r <= dac_nxt;
      leb_r <= leb_nxt;
      act_a_r <= act_a_nxt;
      act_b_r <= act_b_nxt;
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
    end
  end

  // ----------------------------------------
  // input synchroniser and debounce clock
  // ----------------------------------------
  logic [5:0] meta_r, meta_nxt, raw_q_r, raw_q_nxt;
  logic div_r, div_nxt;
  logic db_tick;

  // first stage feeds only the second stage
  always_comb begin
    meta_nxt = cmp_raw;
    raw_q_nxt = meta_r;
    div_nxt = ~div_r;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= 6'h00;
      raw_q_r <= 6'h00;
      div_r <= 1'b0;
    end else begin
      meta_r <= meta_nxt;
      raw_q_r <= raw_q_nxt;
      div_r <= div_nxt;
    end
  end

  // debounce clock is fsys or fsys/2
  assign db_tick = sync_db_r[BIT_FDBDL] ? div_r : 1'b1;

  // ----------------------------------------
  // output conditioning and filters
  // ----------------------------------------
  logic [5:0] power_en, cond, filt;
  logic sync_comp_output, trig_src, dly_trig;

  // disabled channel reads as idle low
  assign power_en[0] = sync_b_r[BIT_POWER_EN];
  assign sync_comp_output = raw_q_r[0] ^ sync_b_r[BIT_OUT_INVERT];
  assign cond[0] = power_en[0] & sync_comp_output;
  assign trig_src = sync_b_r[BIT_TRIG_SRC] ? sync_comp_output : pulse_gen_input_pin;

  // sync channel: interrupt filter and delayed trigger
  cmp_debounce u_sync_db (
    .pclk(pclk),
    .presetn(presetn),
    .tick(db_tick),
    .sel(sync_db_r[5:0]),
    .din(cond[0]),
    .dout(filt[0])
  );

  cmp_debounce u_sync_dly (
    .pclk(pclk),
    .presetn(presetn),
    .tick(db_tick),
    .sel(sync_dly_r[5:0]),
    .din(trig_src),
    .dout(dly_trig)
  );

  // five protection channels share one structure
  for (genvar n = 1; n < NUM_CHAN; n++) begin : g_prot
    assign power_en[n] = prot_b_r[n][BIT_POWER_EN];
    assign cond[n] = power_en[n] & (raw_q_r[n] ^ prot_b_r[n][BIT_OUT_INVERT]);
    cmp_debounce u_db (
      .pclk(pclk),
      .presetn(presetn),
      .tick(db_tick),
      .sel({3'b000, prot_b_r[n][2:0]}),
      .din(cond[n]),
      .dout(filt[n])
    );
  end

  // ----------------------------------------
  // edge detect and interrupt
  // ----------------------------------------
  logic [5:0] filt_d_r, filt_d_nxt;

  // pulse on the active edge of each filtered output
  always_comb begin
    filt_d_nxt = filt;
    pulse_nxt = (IRQ_RISE_SEL & filt & ~filt_d_r) | (~IRQ_RISE_SEL & ~filt & filt_d_r);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt_d_r <= 6'h00;
      pulse_r <= 6'h00;
    end else begin
      filt_d_r <= filt_d_nxt;
      pulse_r <= pulse_nxt;
    end
  end

  assign irq_pulse = pulse_r;
  assign irq = |(stat_r & mask_r);

  // ----------------------------------------
  // routing and analog settings
  // ----------------------------------------
  assign route.sync_delayed_trigger = dly_trig;
  assign route.sync_filtered_out = filt[0];
  assign route.chan_filtered_out = filt[5:1];
  assign route.chan3_blanking_enable = leb_r[BIT_BLANK_EN];

  always_comb begin
    analog_ctl.chan_power_enable = power_en;
    analog_ctl.calib_mode[0] = sync_a_r[BIT_CALIB_MODE];
    for (int k = 1; k < NUM_CHAN; k++) begin
      analog_ctl.calib_mode[k] = prot_a_r[k][BIT_CALIB_MODE];
    end
    analog_ctl.sync_offset_trim = sync_a_r[5:0];
    analog_ctl.sync_ctl_b = sync_b_r;
    analog_ctl.prot_ctl_a = prot_a_r;
    analog_ctl.prot_dac = dac_r;
    analog_ctl.blanking = leb_r;
    analog_ctl.action_a = act_a_r;
    analog_ctl.action_b = act_b_r;
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  logic [7:0] rd_byte;

  always_comb begin
    rd_byte = 8'h00;
    unique case (dec.id)
      RID_SYNC_A: rd_byte = {raw_q_r[0], sync_a_r[6:0]};
      RID_SYNC_B: rd_byte = sync_b_r;
      RID_SYNC_DB: rd_byte = sync_db_r;
      RID_SYNC_DLY: rd_byte = sync_dly_r;
      RID_PROT_A: rd_byte = {raw_q_r[dec.ch], prot_a_r[dec.ch][6:0]};
      RID_PROT_B: rd_byte = prot_b_r[dec.ch] | ({7'h00, filt[dec.ch]} << BIT_CHAN_VOD);
      RID_DAC: rd_byte = dac_r[dec.ch];
      RID_LEB: rd_byte = leb_r;
      RID_ACT_A: rd_byte = act_a_r;
      RID_ACT_B: rd_byte = act_b_r;
      RID_STAT: rd_byte = {2'b00, stat_r};
      RID_MASK: rd_byte = {2'b00, mask_r};
      RID_NONE: rd_byte = 8'h00;
    endcase
    prdata = {24'h000000, rd_byte};
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_raw_read;
    psel && !pwrite && dec.id == RID_SYNC_A |-> prdata[BIT_RAW_OUT] == raw_q_r[0];
  endproperty
  a_raw_read: assert property (p_raw_read) else $error("raw output bit wrong");

  property p_trim_write;
    wr_en && dec.id == RID_SYNC_A |=> analog_ctl.sync_offset_trim == $past(pwdata[5:0])
      && analog_ctl.calib_mode[0] == $past(pwdata[BIT_CALIB_MODE]);
  endproperty
  a_trim_write: assert property (p_trim_write) else $error("trim or mode not stored");

  property p_fall_irq;
    $fell(filt[0]) |=> irq_pulse[0] ##1 !irq_pulse[0];
  endproperty
  a_fall_irq: assert property (p_fall_irq) else $error("channel 0 falling edge missed");

  property p_rise_irq;
    $rose(filt[4]) |=> irq_pulse[4] ##1 !irq_pulse[4];
  endproperty
  a_rise_irq: assert property (p_rise_irq) else $error("channel 4 rising edge missed");

  property p_no_rise_irq;
    $rose(filt[0]) |=> !irq_pulse[0];
  endproperty
  a_no_rise_irq: assert property (p_no_rise_irq) else $error("channel 0 fired on rise");

  property p_route;
    route.sync_filtered_out == filt[0] && route.chan_filtered_out[4] == filt[4]
      && route.chan3_blanking_enable == leb_r[BIT_BLANK_EN];
  endproperty
  a_route: assert property (p_route) else $error("routing mismatch");

  property p_power_off;
    !sync_b_r[BIT_POWER_EN] && sync_db_r[5:0] == 6'h00 |=> !filt[0];
  endproperty
  a_power_off: assert property (p_power_off) else $error("disabled channel 0 active");

  property p_trig_pin;
    !sync_b_r[BIT_TRIG_SRC] && sync_dly_r[5:0] == 6'h00 && $stable(sync_dly_r)
      |=> route.sync_delayed_trigger == $past(pulse_gen_input_pin);
  endproperty
  a_trig_pin: assert property (p_trig_pin) else $error("trigger source not pin");

  property p_invert;
    sync_b_r[BIT_POWER_EN] && sync_db_r[5:0] == 6'h00 && $stable(sync_b_r) && $stable(sync_db_r)
      |=> filt[0] == ($past(raw_q_r[0]) ^ $past(sync_b_r[BIT_OUT_INVERT]));
  endproperty
  a_invert: assert property (p_invert) else $error("invert control wrong");

  property p_status_set;
    pulse_r[0] |=> stat_r[0];
  endproperty
  a_status_set: assert property (p_status_set) else $error("status not set by edge");

  c_fall: cover property ($fell(filt[1]) ##2 irq);
  c_rise4: cover property (irq_pulse[4]);
  c_trig: cover property ($rose(route.sync_delayed_trigger));

endmodule

// [test/cmp_analog_model.sv]
/*
  Behavioural model of the six analog comparator cores.
  Assumes the bench gives the wanted comparison result per channel on level.
*/
`timescale 1ns/1ps

module cmp_analog_model (
  // clock
  input wire logic pclk,
  // settings and wanted results
  input wire cmp_pkg::analog_ctl_t analog_ctl,
  input wire logic [5:0] level,
  // comparator outputs
  output logic [5:0] cmp_raw
);
  import cmp_pkg::*;

  // ----------------------------------------
  // comparator cores
  // ----------------------------------------
  // one output per channel, 0 sync and 1..5 protect
  // a core without power drives low
  // the comparator pins are taken as already shared
  // one cycle of analog settling, so edges never land on the bench edge
  always_ff @(posedge pclk) begin
    cmp_raw <= level & analog_ctl.chan_power_enable;
  end
endmodule

// [test/cmp_bank_tb.sv]
/*
  Self-checking bench for the comparator control bank.
  Assumes the analog model in cmp_analog_model and an APB master here.
*/
`timescale 1ns/1ps

module cmp_bank_tb;
  import cmp_pkg::*;

  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [5:0] level = 6'h00;
  logic pin = 1'b0;
  logic [5:0] cmp_raw;
  analog_ctl_t analog_ctl;
  route_t route;
  logic [5:0] irq_pulse;
  logic irq;
  int pcnt [6] = '{0, 0, 0, 0, 0, 0};
  int mismatches = 0;
  int compares = 0;
  logic [31:0] q;
  logic e;

  // ----------------------------------------
  // clock, instances, pulse counters
  // ----------------------------------------
  always #25 pclk = ~pclk;

  cmp_bank u_cmp_bank (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmp_raw(cmp_raw),
    .pulse_gen_input_pin(pin), .analog_ctl(analog_ctl), .route(route), .irq_pulse(irq_pulse), .irq(irq));
  cmp_analog_model u_cmp_analog_model (.pclk(pclk), .analog_ctl(analog_ctl), .level(level), .cmp_raw(cmp_raw));

  // counts interrupt pulses, one per qualifying edge expected
  always @(posedge pclk) begin
    for (int i = 0; i < 6; i++) begin
      if (irq_pulse[i] === 1'b1) begin
        pcnt[i]++;
      end
    end
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one apb transfer; holds everything until pready is seen high or 50 access cycles pass
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // later checks look at settled outputs, away from the launching edge
    @(negedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check("read data", q, exp);
  endtask

  // the walk takes six edges from input to status; eight leave margin
  // ends mid-cycle so outputs and pulse counts are settled when read
  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // watchdog, far beyond the few hundred cycles of the run
  initial begin
    #(50 * 20000);
    mismatches++;
    complete_run();
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFF_SYNC_CTL_A, 32'h20);
    rd(OFF_SYNC_CTL_B, 32'h04);
    wr(OFF_SYNC_CTL_A, 32'hFF);
    rd(OFF_SYNC_CTL_A, 32'h7F);
    check("calib mode", 32'(analog_ctl.calib_mode[0]), 32'h1);
    check("trim", 32'(analog_ctl.sync_offset_trim), 32'h3F);
    wr(OFF_SYNC_CTL_A, 32'h20);
    check("calib mode", 32'(analog_ctl.calib_mode[0]), 32'h0);
    apb(1'b0, 8'hFC, 32'h0);
    check("unmapped data", q, 32'h0);
    check("unmapped err", 32'(e), 32'h1);
    wr(OFF_INT_MASK, 32'h3F);
    // sync channel, bypass filter, comparator as trigger source
    wr(OFF_SYNC_CTL_B, 32'h84);
    check("power", 32'(analog_ctl.chan_power_enable[0]), 32'h1);
    level[0] <= 1'b1;
    settle(8);
    rd(OFF_SYNC_CTL_A, 32'hA0);
    check("sync out", 32'(route.sync_filtered_out), 32'h1);
    check("trigger", 32'(route.sync_delayed_trigger), 32'h1);
    check("rise pulse", 32'(pcnt[0]), 32'h0);
    level[0] <= 1'b0;
    settle(8);
    check("fall pulse", 32'(pcnt[0]), 32'h1);
    check("irq", 32'(irq), 32'h1);
    rd(OFF_INT_STATUS, 32'h01);
    wr(OFF_INT_STATUS, 32'h01);
    check("irq clear", 32'(irq), 32'h0);
    // invert with the pin as trigger source
    wr(OFF_SYNC_CTL_B, 32'h88);
    settle(8);
    check("inverted", 32'(route.sync_filtered_out), 32'h1);
    rd(OFF_SYNC_CTL_A, 32'h20);
    @(posedge pclk);
    pin <= 1'b1;
    settle(8);
    check("pin trigger", 32'(route.sync_delayed_trigger), 32'h1);
    @(posedge pclk);
    pin <= 1'b0;
    settle(8);
    check("pin trigger", 32'(route.sync_delayed_trigger), 32'h0);
    // delay code 4 holds the trigger back; upper bits read 0
    wr(OFF_SYNC_DELAY, 32'hC4);
    rd(OFF_SYNC_DELAY, 32'h04);
    @(posedge pclk);
    pin <= 1'b1;
    settle(2);
    check("delayed trigger", 32'(route.sync_delayed_trigger), 32'h0);
    settle(8);
    check("delayed trigger", 32'(route.sync_delayed_trigger), 32'h1);
    // debounce code 8 rejects a two-cycle glitch; channel 0 masked
    wr(OFF_SYNC_CTL_B, 32'h80);
    settle(8);
    wr(OFF_INT_STATUS, 32'h3F);
    wr(OFF_INT_MASK, 32'h3E);
    wr(OFF_SYNC_DEBOUNCE, 32'h08);
    level[0] <= 1'b1;
    settle(2);
    level[0] <= 1'b0;
    settle(20);
    check("glitch", 32'(route.sync_filtered_out), 32'h0);
    level[0] <= 1'b1;
    settle(30);
    check("debounced", 32'(route.sync_filtered_out), 32'h1);
    level[0] <= 1'b0;
    settle(30);
    rd(OFF_INT_STATUS, 32'h01);
    check("masked irq", 32'(irq), 32'h0);
    wr(OFF_INT_MASK, 32'h3F);
    check("unmasked irq", 32'(irq), 32'h1);
    wr(OFF_INT_STATUS, 32'h01);
    // half-rate debounce clock doubles the window; bit 6 reads 0
    wr(OFF_SYNC_DEBOUNCE, 32'hC8);
    rd(OFF_SYNC_DEBOUNCE, 32'h88);
    level[0] <= 1'b1;
    settle(12);
    check("half rate", 32'(route.sync_filtered_out), 32'h0);
    settle(20);
    check("half rate", 32'(route.sync_filtered_out), 32'h1);
    // protect channels: channel 4 rising, the rest falling
    for (int n = 1; n < 6; n++) begin
      wr(OFF_PROT_CTL_B_BASE + 8'(4 * n), 32'h80);
      level[n] <= 1'b1;
      settle(8);
      check("chan out", 32'(route.chan_filtered_out[n]), 32'h1);
      rd(OFF_PROT_CTL_B_BASE + 8'(4 * n), 32'h90);
      check("rise pulse", 32'(pcnt[n]), (n == 4) ? 32'h1 : 32'h0);
      level[n] <= 1'b0;
      settle(8);
      check("one pulse", 32'(pcnt[n]), 32'h1);
      wr(OFF_PROT_CTL_B_BASE + 8'(4 * n), 32'h00);
    end
    rd(OFF_INT_STATUS, 32'h3E);
    wr(OFF_LEB_CTL, 32'h80);
    check("blanking", 32'(route.chan3_blanking_enable), 32'h1);
    complete_run();
  end
endmodule
